// >>> rtl/swrs_regs.vh
`ifndef SWRS_REGS_VH
`define SWRS_REGS_VH
// apb byte addresses of the software-visible registers
`define SWRS_PSW_ADDR    12'h000
`define SWRS_XFLAG_ADDR  12'h004
`define SWRS_PC_ADDR     12'h008
`define SWRS_CMD_ADDR    12'h00c
`define SWRS_ALU_ADDR    12'h010
`define SWRS_STAT_ADDR   12'h014
`define SWRS_MEM_BASE    12'h100
`define SWRS_MEM_LAST    12'h1fc
// status word field positions
`define SWRS_CY_BIT      7
`define SWRS_HC_BIT      6
`define SWRS_F0_BIT      5
`define SWRS_BS_BIT      4
// reset values
`define SWRS_PSW_RST     8'h08
`define SWRS_PC_RST      12'h000
// stack geometry in register memory
`define SWRS_STACK_BASE  6'h08
`define SWRS_BANK0_BASE  6'h00
`define SWRS_BANK1_BASE  6'h18
// command codes written to the command register
`define SWRS_CMD_CALL    3'h1
`define SWRS_CMD_INTR    3'h2
`define SWRS_CMD_RETR    3'h3
`define SWRS_CMD_RET     3'h4
`define SWRS_CMD_JUMP    3'h5
`define SWRS_CMD_ADD     3'h6
`define SWRS_CMD_SUB     3'h7
`endif

// >>> rtl/swrs_ram.v
`timescale 1ns/1ps
// register memory: two single-cycle write ports, two read ports
module swrs_ram #(
	parameter AW = 6,
	parameter DEPTH = 64
) (
	input  wire          clk,
	input  wire          we_a,
	input  wire [AW-1:0] addr_a,
	input  wire [7:0]    wdata_a,
	input  wire          we_b,
	input  wire [AW-1:0] addr_b,
	input  wire [7:0]    wdata_b,
	input  wire [AW-1:0] raddr_a,
	output wire [7:0]    rdata_a,
	input  wire [AW-1:0] raddr_b,
	output wire [7:0]    rdata_b
);
	reg [7:0] mem [0:DEPTH-1]; // contents are undefined after power up

	// port b wins when both hit one byte
	always @(posedge clk) begin
		if (we_a) begin
			mem[addr_a] <= wdata_a;
		end
		if (we_b) begin
			mem[addr_b] <= wdata_b;
		end
	end

	assign rdata_a = mem[raddr_a];
	assign rdata_b = mem[raddr_b];
endmodule

// >>> rtl/swrs_top.v
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "swrs_regs.vh"
// How it works
// [RULE1] four flags live in status word upper half
// [RULE2] carry holds last add carry or borrow
// [RULE3] half carry holds bit3 to bit4 carry
// [RULE4] user flag zero is plain software bit
// [RULE5] bank select picks locations 0-7 or 18-1f
// [RULE6] flag one, timer, bank flag kept apart
// [RULE7] stack pointer is status word bits 2:0
// [RULE8] stack is locations 8-17, eight levels
// [RULE9] pointer names next free level, 8+2n
// [RULE10] push writes pc low byte at lower address
// [RULE11] push upper byte: flags plus pc 11-8
// [RULE12] after push, pointer increments by one
// [RULE13] pop decrements pointer first, then restores
// [RULE14] interrupt pushes return address and flags
// [RULE15] call pushes; full return restores both
// [RULE16] plain return restores program counter only
// [RULE17] stack bytes stay ordinary indirect memory
// [RULE18] 64 bytes; index pointers reach all bytes
// [RULE19] jump or call loads bank bit from flag
// [RULE20] flags in bits 7-4, pc 11-8 in 3-0
// [RULE21] pointer wraps modulo eight, no overflow
module swrs_top #(
	parameter MEM_DEPTH = 64
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg  [7:0]  status_word,
	output reg  [11:0] program_counter,
	output reg  [5:0]  bank_base
);
	// flag and pointer storage
	reg [3:0]  flags_r;              // carry, half carry, user flag zero, bank select
	reg [2:0]  stack_level_pointer_r; // next free level
	reg        user_flag_one_r;      // outside the status word
	reg        timer_overflow_flag_r; // outside the status word, set by software here
	reg        designated_bank_flag_r; // copied into the bank bit on jump or call
	reg [11:0] pc_r;                 // program counter
	reg [7:0]  alu_a_r;              // operand a for add/sub
	reg [7:0]  alu_b_r;              // operand b
	reg [7:0]  alu_res_r;            // last result

	// apb decode
	wire        setup    = psel & ~penable;
	wire        access   = psel & penable;
	wire        wr_acc   = access & pwrite & pready; // lands only on the answering edge
	wire        rd_setup = setup & ~pwrite;
	wire        in_mem   = (paddr >= `SWRS_MEM_BASE) && (paddr <= `SWRS_MEM_LAST);
	wire [5:0]  mem_idx  = paddr[7:2];
	wire        known    = in_mem || (paddr == `SWRS_PSW_ADDR) ||
	                       (paddr == `SWRS_XFLAG_ADDR) || (paddr == `SWRS_PC_ADDR) ||
	                       (paddr == `SWRS_CMD_ADDR) || (paddr == `SWRS_ALU_ADDR) ||
	                       (paddr == `SWRS_STAT_ADDR) || (paddr[11:3] == 9'h003);
	wire        cmd_wr   = wr_acc && (paddr == `SWRS_CMD_ADDR);
	wire [2:0]  cmd      = pwdata[2:0];

	// sequencer: a push or pop takes two cycles so the bus stalls meanwhile
	localparam ST_IDLE = 2'd0;
	localparam ST_PUSH = 2'd1;
	localparam ST_POP  = 2'd2;
	localparam ST_DONE = 2'd3;
	localparam [7:0] PSW_RST_V = `SWRS_PSW_RST; // sized copy so the flag field can be sliced
	reg [1:0]  state_r;
	reg [1:0]  state_nxt;
	// answer once per transfer, in setup or in a stalled access, only when the sequencer is free
	wire       resp = psel && !pready && (state_r == ST_IDLE) && (state_nxt == ST_IDLE);
	reg        restore_flags_r;      // full return restores the flags too
	reg [11:0] target_r;             // call destination

	// stack level byte addresses
	wire [2:0] pop_level  = stack_level_pointer_r - 3'd1; // [RULE21]
	wire [5:0] push_lo    = `SWRS_STACK_BASE + {2'b00, stack_level_pointer_r, 1'b0}; // [RULE9]
	wire [5:0] push_hi    = push_lo | 6'h01;
	wire [5:0] pop_lo     = `SWRS_STACK_BASE + {2'b00, pop_level, 1'b0}; // [RULE8]
	wire [5:0] pop_hi     = pop_lo | 6'h01;

	// index pointer: paddr bit 2 selects pointer 0 or 1 of current bank for indirect access
	wire [5:0] bank_now   = flags_r[0] ? `SWRS_BANK1_BASE : `SWRS_BANK0_BASE; // [RULE5]
	wire [7:0] ptr0_val;
	wire [7:0] ptr1_val;

	// ram ports
	wire       stack_we   = (state_r == ST_PUSH);
	wire [7:0] stack_lo_d = pc_r[7:0]; // [RULE10]
	wire [7:0] stack_hi_d = {flags_r, pc_r[11:8]}; // [RULE11] [RULE20]
	wire       mem_we     = wr_acc && in_mem;
	wire       ind_wr     = wr_acc && (paddr[11:3] == 9'h003);
	wire [5:0] ind_addr   = paddr[2] ? ptr1_val[5:0] : ptr0_val[5:0]; // [RULE18]
	wire [5:0] cpu_waddr  = ind_wr ? ind_addr : mem_idx;
	wire [7:0] rd_lo;
	wire [7:0] rd_hi;
	wire [7:0] bus_rd;
	wire [5:0] bus_raddr  = (paddr[11:3] == 9'h003) ? ind_addr : mem_idx;

	// memory used by both the bus and the stack; push uses both write ports
	swrs_ram #(
		.AW    (6),
		.DEPTH (MEM_DEPTH)
	) u_ram (
		.clk     (pclk),
		.we_a    (stack_we | ((mem_we | ind_wr) & (state_r == ST_IDLE))), // [RULE17]
		.addr_a  (stack_we ? push_lo : cpu_waddr),
		.wdata_a (stack_we ? stack_lo_d : pwdata[7:0]),
		.we_b    (stack_we),
		.addr_b  (push_hi),
		.wdata_b (stack_hi_d),
		.raddr_a (state_r == ST_POP ? pop_lo : bus_raddr),
		.rdata_a (rd_lo),
		.raddr_b (state_r == ST_POP ? pop_hi : bank_now),
		.rdata_b (rd_hi)
	);
	assign bus_rd = rd_lo;

	// index pointer shadows, one pair per bank so a bank switch needs no reload
	reg [7:0] b0_ptr0_r;             // bank zero, index pointer zero
	reg [7:0] b0_ptr1_r;             // bank zero, index pointer one
	reg [7:0] b1_ptr0_r;             // bank one, index pointer zero
	reg [7:0] b1_ptr1_r;             // bank one, index pointer one
	assign ptr0_val = flags_r[0] ? b1_ptr0_r : b0_ptr0_r; // [RULE5]
	assign ptr1_val = flags_r[0] ? b1_ptr1_r : b0_ptr1_r;

	// shadows follow bus writes; the stack area never overlaps the pointer bytes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			b0_ptr0_r <= 8'h00;
			b0_ptr1_r <= 8'h00;
			b1_ptr0_r <= 8'h00;
			b1_ptr1_r <= 8'h00;
		end else if ((mem_we | ind_wr) && state_r == ST_IDLE) begin
			if (cpu_waddr == `SWRS_BANK0_BASE) begin
				b0_ptr0_r <= pwdata[7:0];
			end
			if (cpu_waddr == (`SWRS_BANK0_BASE | 6'h01)) begin
				b0_ptr1_r <= pwdata[7:0];
			end
			if (cpu_waddr == `SWRS_BANK1_BASE) begin
				b1_ptr0_r <= pwdata[7:0];
			end
			if (cpu_waddr == (`SWRS_BANK1_BASE | 6'h01)) begin
				b1_ptr1_r <= pwdata[7:0];
			end
		end
	end

	// next state
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (cmd_wr && (cmd == `SWRS_CMD_CALL || cmd == `SWRS_CMD_INTR)) begin
					state_nxt = ST_PUSH; // [RULE14] [RULE15]
				end else if (cmd_wr && (cmd == `SWRS_CMD_RETR || cmd == `SWRS_CMD_RET)) begin
					state_nxt = ST_POP;
				end
			end
			ST_PUSH: state_nxt = ST_DONE;
			ST_POP:  state_nxt = ST_DONE;
			ST_DONE: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	// arithmetic for carry and half carry
	wire       is_sub  = (cmd == `SWRS_CMD_SUB);
	wire [8:0] sum     = is_sub ? ({1'b0, alu_a_r} - {1'b0, alu_b_r})
	                            : ({1'b0, alu_a_r} + {1'b0, alu_b_r});
	wire [4:0] nib_sum = {1'b0, alu_a_r[3:0]} + {1'b0, alu_b_r[3:0]};

	// core state
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r                <= ST_IDLE;
			flags_r                <= PSW_RST_V[7:4];
			stack_level_pointer_r  <= 3'd0;
			user_flag_one_r        <= 1'b0;
			timer_overflow_flag_r  <= 1'b0;
			designated_bank_flag_r <= 1'b0;
			pc_r                   <= `SWRS_PC_RST;
			alu_a_r                <= 8'h00;
			alu_b_r                <= 8'h00;
			alu_res_r              <= 8'h00;
			restore_flags_r        <= 1'b0;
			target_r               <= 12'h000;
		end else begin
			state_r <= state_nxt;
			case (state_r)
				ST_IDLE: begin
					if (wr_acc && paddr == `SWRS_PSW_ADDR) begin
						flags_r               <= pwdata[7:4]; // [RULE1] [RULE4]
						stack_level_pointer_r <= pwdata[2:0]; // [RULE7]
					end
					if (wr_acc && paddr == `SWRS_XFLAG_ADDR) begin
						user_flag_one_r        <= pwdata[0]; // [RULE6]
						timer_overflow_flag_r  <= pwdata[1];
						designated_bank_flag_r <= pwdata[2];
					end
					if (wr_acc && paddr == `SWRS_PC_ADDR) begin
						pc_r <= pwdata[11:0];
					end
					if (wr_acc && paddr == `SWRS_ALU_ADDR) begin
						alu_a_r <= pwdata[7:0];
						alu_b_r <= pwdata[15:8];
					end
					if (cmd_wr) begin
						target_r        <= {designated_bank_flag_r, pwdata[14:4]}; // [RULE19]
						restore_flags_r <= (cmd == `SWRS_CMD_RETR);
						case (cmd)
							`SWRS_CMD_JUMP: begin
								pc_r <= {designated_bank_flag_r, pwdata[14:4]}; // [RULE19]
							end
							`SWRS_CMD_ADD: begin
								alu_res_r  <= sum[7:0];
								flags_r[3] <= sum[8]; // [RULE2]
								flags_r[2] <= nib_sum[4]; // [RULE3]
							end
							`SWRS_CMD_SUB: begin
								alu_res_r  <= sum[7:0];
								flags_r[3] <= sum[8]; // [RULE2] borrow
							end
							default: begin
								alu_res_r <= alu_res_r;
							end
						endcase
					end
				end
				ST_PUSH: begin
					// both bytes written this edge, so the pointer moves now
					stack_level_pointer_r <= stack_level_pointer_r + 3'd1; // [RULE12] [RULE21]
					pc_r                  <= target_r;
				end
				ST_POP: begin
					stack_level_pointer_r <= pop_level; // [RULE13]
					pc_r                  <= {rd_hi[3:0], rd_lo}; // [RULE16]
					if (restore_flags_r) begin
						flags_r <= rd_hi[7:4]; // [RULE15]
					end
				end
				default: begin
					restore_flags_r <= restore_flags_r;
				end
			endcase
		end
	end

	// apb answer: ready one cycle after setup when idle, stalls during stack work
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= resp;
			pslverr <= resp && !known;
			if (resp && !pwrite) begin
				if (in_mem || paddr[11:3] == 9'h003) begin
					prdata <= {24'h000000, bus_rd};
				end else if (paddr == `SWRS_PSW_ADDR) begin
					prdata <= {24'h000000, flags_r, 1'b1, stack_level_pointer_r};
				end else if (paddr == `SWRS_XFLAG_ADDR) begin
					prdata <= {29'h00000000, designated_bank_flag_r,
					           timer_overflow_flag_r, user_flag_one_r};
				end else if (paddr == `SWRS_PC_ADDR) begin
					prdata <= {20'h00000, pc_r};
				end else if (paddr == `SWRS_ALU_ADDR) begin
					prdata <= {8'h00, alu_res_r, alu_b_r, alu_a_r};
				end else if (paddr == `SWRS_STAT_ADDR) begin
					prdata <= {30'h00000000, state_r};
				end else begin
					prdata <= 32'h00000000;
				end
			end
		end
	end

	// visible copies for the rest of the core
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_word     <= `SWRS_PSW_RST;
			program_counter <= `SWRS_PC_RST;
			bank_base       <= `SWRS_BANK0_BASE;
		end else begin
			status_word     <= {flags_r, 1'b1, stack_level_pointer_r};
			program_counter <= pc_r;
			bank_base       <= bank_now; // [RULE5]
		end
	end
endmodule

// >>> test/swrs_top_assertions.sv
`timescale 1ns/1ps
`include "swrs_regs.vh"
// bus-side checks on the top-level ports
module swrs_chk (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [7:0]  status_word,
	input wire [5:0]  bank_base
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire       done = psel && penable && pready; // access completing
	wire [2:0] ptr  = status_word[2:0];          // stack level pointer
	spare_bit_a: assert property (status_word[3] == 1'b1)
		else $error("status bit 3 low");
	bank_map_a: assert property (status_word[4] == $past(status_word[4]) |->
		bank_base == (status_word[4] ? `SWRS_BANK1_BASE : `SWRS_BANK0_BASE))
		else $error("bank base does not follow bank select");
	// a pointer move not caused by a bus write is a single step, wrapping
	ptr_step_a: assert property (ptr != $past(ptr) &&
		!$past(done && pwrite && paddr == `SWRS_PSW_ADDR, 2) |->
		ptr == $past(ptr) + 3'h1 || ptr == $past(ptr) - 3'h1)
		else $error("pointer jumped");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	unmapped_err_a: assert property (done && paddr == 12'h020 |-> pslverr)
		else $error("unmapped access not refused");
	psw_read_a: assert property (done && !pwrite && paddr == `SWRS_PSW_ADDR |->
		prdata == {24'h0, status_word}) else $error("status read differs");
endmodule

// >>> test/swrs_top_tb.sv
`timescale 1ns/1ps
`include "swrs_regs.vh"
module swrs_top_tb;
	reg          pclk = 1'b0;
	reg          presetn = 1'b0;
	reg          psel = 1'b0;
	reg          penable = 1'b0;
	reg          pwrite = 1'b0;
	reg  [11:0]  paddr = 12'h000;
	reg  [31:0]  pwdata = 32'h0;
	wire [31:0]  prdata;
	wire         pready;
	wire         pslverr;
	wire [7:0]   status_word;
	wire [11:0]  program_counter;
	wire [5:0]   bank_base;
	integer      bad_count = 0;
	integer      n_compared = 0;
	integer      i;
	integer      lv;            // byte index of the stack level in use
	logic [32:0] notes[$];      // expected {pslverr, prdata} per read
	logic [7:0]  mem[0:63];     // register memory model
	logic [11:0] pcm;           // program counter model
	logic [3:0]  flg;           // carry, half carry, user0, bank select
	logic [2:0]  ptr;           // stack level pointer model
	logic [31:0] rnd;           // lfsr state
	logic [8:0]  s9;
	logic [4:0]  h5;
	always #50 pclk = ~pclk;
	swrs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .status_word(status_word), .program_counter(program_counter),
		.bank_base(bank_base));
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task check(input [32:0] seen, input [32:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task complete_run;
		if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// one apb transfer; waits on pready since a command stalls the slave
	task apb(input w, input [11:0] a, input [31:0] d);
		integer n;
		n = 0;
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do begin @(posedge pclk); n = n + 1; end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1) bad_count = bad_count + 1;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(input [11:0] a, input [32:0] e);
		notes.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task state_rd;
		rd(`SWRS_PSW_ADDR, {25'h0, flg, 1'b1, ptr});
		rd(`SWRS_PC_ADDR, {21'h0, pcm});
		check({21'h0, program_counter}, {21'h0, pcm});
	endtask
	task mrd(input integer x);
		rd(`SWRS_MEM_BASE + 4 * x, {25'h0, mem[x]});
	endtask
	task cmd(input [2:0] c, input [10:0] t);
		apb(1'b1, `SWRS_CMD_ADDR, {17'h0, t, 1'b0, c});
	endtask
	// reads are compared at the edge where the slave answers
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, notes.pop_front());
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count = bad_count + 1;
		complete_run;
	end
	initial begin
		rnd = 32'hd38327a4; flg = 4'h0; ptr = 3'h0; pcm = 12'h000;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		state_rd;
		apb(1'b1, `SWRS_XFLAG_ADDR, 32'h4);
		rd(`SWRS_XFLAG_ADDR, 33'h4);
		state_rd;
		// three adds then three subtracts on random operands
		for (i = 0; i < 6; i = i + 1) begin
			apb(1'b1, `SWRS_ALU_ADDR, {16'h0, rnd[15:0]});
			s9 = (i < 3) ? {1'b0, rnd[7:0]} + {1'b0, rnd[15:8]} : {1'b0, rnd[7:0]} - {1'b0, rnd[15:8]};
			h5 = {1'b0, rnd[3:0]} + {1'b0, rnd[11:8]};
			cmd((i < 3) ? `SWRS_CMD_ADD : `SWRS_CMD_SUB, 11'h0);
			flg[3] = s9[8];
			if (i < 3) flg[2] = h5[4];
			rd(`SWRS_ALU_ADDR, {9'h0, s9[7:0], rnd[15:0]});
			state_rd;
			rnd = lfsr(rnd);
		end
		cmd(`SWRS_CMD_JUMP, 11'h5a5);
		pcm = 12'hda5;
		state_rd;
		// eight pushes fill every level and wrap the pointer back to zero
		for (i = 0; i < 8; i = i + 1) begin
			flg = rnd[19:16];
			apb(1'b1, `SWRS_PSW_ADDR, {24'h0, flg, 1'b1, ptr});
			lv = 8 + 2 * ptr;
			mem[lv] = pcm[7:0];
			mem[lv + 1] = {flg, pcm[11:8]};
			cmd(i[0] ? `SWRS_CMD_INTR : `SWRS_CMD_CALL, rnd[10:0]);
			ptr = ptr + 3'h1;
			pcm = {1'b1, rnd[10:0]};
			mrd(lv);
			mrd(lv + 1);
			state_rd;
			check({27'h0, bank_base}, flg[0] ? 33'h18 : 33'h0);
			rnd = lfsr(rnd);
		end
		mem[22] = rnd[7:0];
		apb(1'b1, `SWRS_MEM_BASE + 12'd88, {24'h0, rnd[7:0]});
		lv = flg[0] ? 24 : 0;
		mem[lv] = 8'h09;
		apb(1'b1, `SWRS_MEM_BASE + 4 * lv, 32'h9);
		rd(12'h018, {25'h0, mem[9]});
		// pops alternate full and plain returns; the first wraps below zero
		for (i = 0; i < 8; i = i + 1) begin
			flg = rnd[23:20];
			apb(1'b1, `SWRS_PSW_ADDR, {24'h0, flg, 1'b1, ptr});
			cmd(i[0] ? `SWRS_CMD_RET : `SWRS_CMD_RETR, 11'h0);
			ptr = ptr - 3'h1;
			lv = 8 + 2 * ptr;
			pcm = {mem[lv + 1][3:0], mem[lv]};
			if (!i[0]) flg = mem[lv + 1][7:4];
			state_rd;
			rnd = lfsr(rnd);
		end
		rd(12'h020, {1'b1, 32'h0});
		apb(1'b1, 12'h020, 32'hff);
		state_rd;
		complete_run;
	end
endmodule
bind swrs_top swrs_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.status_word(status_word), .bank_base(bank_base));
